/* File: ltpam_pkg.sv */
// Constants and types for the logical to physical address mapper
`default_nettype none
package ltpam_pkg;
	localparam int LA_W       = 16;
	localparam int PA_W       = 32;
	localparam int ZONE_W     = 8;
	localparam int SIZE_W     = 5;
	localparam int TGT_W      = 24;
	localparam int UB_W       = 8;
	localparam logic [4:0] SIZE_MIN = 5'h08;
	localparam logic [4:0] SIZE_MAX = 5'h10;
	localparam logic [4:0] ROM_SIZE = 5'h0a;
	localparam logic [15:0] ROM_MIRROR = 16'h03ff;
	localparam logic [15:0] ROM_BASE_LO = 16'h0000;
	localparam logic [SIZE_W-1:0] SIZE_RST = 5'h10;
	localparam logic [TGT_W-1:0]  TGT_RST  = 24'h000000;
	localparam logic [ZONE_W-1:0] ZONE_RST = 8'h00;
	localparam logic [UB_W-1:0]   UB_RST   = 8'h00;
	localparam int NUM_PROG = 2;
	typedef enum logic [1:0] {
		LTPAM_SEL_ROM,
		LTPAM_SEL_LOW,
		LTPAM_SEL_HIGH
	} ltpam_sel_t;
endpackage
`default_nettype wire

/* File: ltpam_zone.sv */
// One programmable code mapper: zone compare and address substitution
`timescale 1ns/1ps
`default_nettype none
module ltpam_zone (
	input  wire logic [15:0] log_addr,
	input  wire logic        code_fetch,
	input  wire logic        enable,
	input  wire logic [4:0]  size_log2,
	input  wire logic [7:0]  zone_src,
	input  wire logic [23:0] target,
	input  wire logic [7:0]  upper_byte,
	output logic             hit,
	output logic [31:0]      phys
);
	wire logic [15:0] mask;
	wire logic [15:0] tgt_lo;
	// Fields outside 8..16 clamp so the low byte always passes through
	assign mask = (size_log2 >= ltpam_pkg::SIZE_MAX) ? 16'hffff
		: (size_log2 <= ltpam_pkg::SIZE_MIN) ? 16'h00ff
		: 16'((17'h00001 << size_log2) - 17'h00001);
	// Low byte never compared
	assign hit = code_fetch && enable
		&& (((log_addr[15:8] ^ zone_src) & ~mask[15:8]) == 8'h00);
	assign tgt_lo = {target[15:0] & ~mask} | (log_addr & mask);
	assign phys = {upper_byte, target[23:16], tgt_lo};
endmodule // ltpam_zone
`default_nettype wire

/* File: ltpam_top.sv */
// Code-space mapper: two programmable mappers above the boot ROM mapper
// Behaviour
// - Each non-internal code fetch becomes a 32-bit physical bus address.
// - Code mappers react only to code fetches, never data accesses.
// - Zones are power-of-two spans 256B..64K, aligned to their size.
// - Five-bit size is log2 of zone; mask is two to that minus one.
// - Compare logical bits 15..8 to zone value outside mask; low byte ignored.
// - Only an enabled mapper with a successful compare claims an access.
// - Masked low bits from logical address; byte 0 always passes through.
// - 24-bit target supplies physical bits 23..8 outside the mask.
// - Unmatched mappers fall to the next lower; lowest always matches.
// - Bus resources decode bits 23..0; 31..24 carry debug information.
// - Internal RAM and internal special registers never reach the bus.
// - Exactly three code mappers: boot ROM plus two programmable.
// - ROM mapper is lowest priority and always enabled after reset.
// - 1K boot ROM appears at every 1K boundary, 64 images.
// - High mapper outranks low, low outranks ROM mapper.
// - Both programmable mappers are disabled after reset, enabled separately.
// - ROM hit places operand or opcode upper byte on bits 31..24.
`timescale 1ns/1ps
`default_nettype none
module ltpam_top (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        acc_valid,
	input  wire logic        acc_code,
	input  wire logic        acc_opcode,
	input  wire logic        acc_internal,
	input  wire logic [15:0] log_addr,
	input  wire logic        cfg_we,
	input  wire logic        cfg_sel_high,
	input  wire logic        cfg_enable,
	input  wire logic [4:0]  cfg_size,
	input  wire logic [7:0]  cfg_zone,
	input  wire logic [23:0] cfg_target,
	input  wire logic [7:0]  cfg_operand_byte,
	input  wire logic [7:0]  cfg_opcode_byte,
	input  wire logic        rom_ub_we,
	input  wire logic [7:0]  rom_operand_upper_byte,
	input  wire logic [7:0]  rom_opcode_upper_byte,
	output logic             bus_valid,
	output logic [31:0]      bus_addr,
	output logic [1:0]       hit_vec,
	output logic [1:0]       map_enabled
);
	localparam int N = ltpam_pkg::NUM_PROG;
	logic [N-1:0]  en_ff;
	logic [4:0]    size_ff   [N];
	logic [7:0]    zone_ff   [N];
	logic [23:0]   tgt_ff    [N];
	logic [7:0]    opnd_ff   [N];
	logic [7:0]    opc_ff    [N];
	logic [7:0]    rom_opnd_ff;
	logic [7:0]    rom_opc_ff;
	wire logic [N-1:0] hit;
	wire logic [31:0]  phys [N];
	wire logic [31:0]  rom_phys;
	wire logic         fetch;
	wire logic [31:0]  sel_addr;
	wire ltpam_pkg::ltpam_sel_t sel;
	wire logic [7:0]   rom_ub;

	// Opcode fetches get their own upper byte so a trace can tell them apart
	function automatic logic [7:0] ub_pick(
		input logic       opcode,
		input logic [7:0] opnd_byte,
		input logic [7:0] opc_byte
	);
		ub_pick = opcode ? opc_byte : opnd_byte;
	endfunction

	// Internal RAM and core registers stay inside the core
	assign fetch = acc_valid && acc_code && !acc_internal;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_map
			wire logic       mine;
			wire logic [7:0] ub;
			assign mine = cfg_we && (cfg_sel_high == (g == 1));
			assign ub = ub_pick(acc_opcode, opnd_ff[g], opc_ff[g]);
			always_ff @(posedge clk_sys)
			begin
				if (srst)
				begin
					en_ff[g]   <= 1'b0;
					size_ff[g] <= ltpam_pkg::SIZE_RST;
					zone_ff[g] <= ltpam_pkg::ZONE_RST;
					tgt_ff[g]  <= ltpam_pkg::TGT_RST;
					opnd_ff[g] <= ltpam_pkg::UB_RST;
					opc_ff[g]  <= ltpam_pkg::UB_RST;
				end
				else if (mine)
				begin
					en_ff[g]   <= cfg_enable;
					size_ff[g] <= cfg_size;
					zone_ff[g] <= cfg_zone;
					tgt_ff[g]  <= cfg_target;
					opnd_ff[g] <= cfg_operand_byte;
					opc_ff[g]  <= cfg_opcode_byte;
				end
			end
			ltpam_zone u_zone (
				.log_addr   (log_addr),
				.code_fetch (fetch),
				.enable     (en_ff[g]),
				.size_log2  (size_ff[g]),
				.zone_src   (zone_ff[g]),
				.target     (tgt_ff[g]),
				.upper_byte (ub),
				.hit        (hit[g]),
				.phys       (phys[g])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rom_opnd_ff <= ltpam_pkg::UB_RST;
			rom_opc_ff  <= ltpam_pkg::UB_RST;
		end
		else if (rom_ub_we)
		begin
			rom_opnd_ff <= rom_operand_upper_byte;
			rom_opc_ff  <= rom_opcode_upper_byte;
		end
	end

	// ROM mirrored every 1K; middle bits kept at zero for a 64K ROM window
	assign rom_ub   = ub_pick(acc_opcode, rom_opnd_ff, rom_opc_ff);
	assign rom_phys = {rom_ub, 8'h00,
		ltpam_pkg::ROM_BASE_LO | (log_addr & ltpam_pkg::ROM_MIRROR)};

	// Fixed priority keeps the choice a pure function of this cycle
	assign sel = hit[1] ? ltpam_pkg::LTPAM_SEL_HIGH
		: hit[0] ? ltpam_pkg::LTPAM_SEL_LOW
		: ltpam_pkg::LTPAM_SEL_ROM;
	assign sel_addr = (sel == ltpam_pkg::LTPAM_SEL_HIGH) ? phys[1]
		: (sel == ltpam_pkg::LTPAM_SEL_LOW) ? phys[0] : rom_phys;

	// Combinational so the address is valid in the access cycle
	assign bus_valid = fetch;
	assign bus_addr  = fetch ? sel_addr : 32'h00000000;
	assign hit_vec   = hit;
	assign map_enabled = en_ff;

	mapper_off_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!en_ff[0] |-> !hit[0])
		else $error("disabled low mapper hit");
	high_off_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!en_ff[1] |-> !hit[1])
		else $error("disabled high mapper hit");
	data_ignored_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!acc_code |-> (hit == 2'b00) && !bus_valid)
		else $error("data access claimed");
	internal_kept_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		acc_internal |-> !bus_valid)
		else $error("internal access forwarded");
	idle_quiet_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		!acc_valid |-> !bus_valid && bus_addr == 32'h00000000)
		else $error("idle cycle drove the bus");
	low_byte_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		bus_valid |-> bus_addr[7:0] == log_addr[7:0])
		else $error("low byte not passed");
	high_wins_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		hit[1] |-> bus_addr == phys[1])
		else $error("high mapper lost priority");
	low_wins_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(hit == 2'b01) |-> bus_addr == phys[0])
		else $error("low mapper lost to rom");
	rom_default_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(bus_valid && hit == 2'b00) |->
		bus_addr[9:0] == log_addr[9:0] && bus_addr[23:10] == 14'h0000)
		else $error("rom image wrong");
	rom_ub_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(bus_valid && hit == 2'b00 && acc_opcode) |->
		bus_addr[31:24] == rom_opc_ff)
		else $error("rom opcode byte wrong");
	rom_operand_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(bus_valid && hit == 2'b00 && !acc_opcode) |->
		bus_addr[31:24] == rom_opnd_ff)
		else $error("rom operand byte wrong");
	reset_off_a: assert property (
		@(posedge clk_sys)
		$past(srst) |-> en_ff == 2'b00)
		else $error("mapper enabled after reset");
	enable_apart_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(cfg_we && !cfg_sel_high) |=> $stable(en_ff[1]))
		else $error("high enable changed by low write");
	target_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(hit == 2'b01 && size_ff[0] == ltpam_pkg::SIZE_MIN) |->
		bus_addr[23:8] == tgt_ff[0][23:8])
		else $error("target not substituted");
	exact_zone_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(hit[0] && size_ff[0] == ltpam_pkg::SIZE_MIN) |->
		log_addr[15:8] == zone_ff[0])
		else $error("small zone compare wrong");
	full_zone_a: assert property (
		@(posedge clk_sys) disable iff (srst)
		(fetch && en_ff[1] && size_ff[1] == ltpam_pkg::SIZE_MAX) |->
		hit[1])
		else $error("full zone missed");

	rom_cov_c: cover property (@(posedge clk_sys) bus_valid && hit == 2'b00);
	low_cov_c: cover property (@(posedge clk_sys) hit == 2'b01);
	high_cov_c: cover property (@(posedge clk_sys) hit == 2'b10);
	both_cov_c: cover property (@(posedge clk_sys) hit == 2'b11);
	idle_cov_c: cover property (@(posedge clk_sys) !acc_valid);
endmodule // ltpam_top
`default_nettype wire

/* File: ltpam_core.sv */
// Core model: presents one access at a time to the mapper
`timescale 1ns/1ps
`default_nettype none
module ltpam_core (
	output logic        acc_valid,
	output logic        acc_code,
	output logic        acc_opcode,
	output logic        acc_internal,
	output logic [15:0] log_addr
);
	// Kind k is {code, opcode, internal}; held until the next call
	task automatic fetch(input logic [15:0] a, input logic [2:0] k);
		acc_valid = 1'b1;
		acc_code = k[2];
		acc_opcode = k[1];
		acc_internal = k[0];
		log_addr = a;
	endtask
	// Drop the request between accesses
	task automatic idle();
		acc_valid = 1'b0;
	endtask
endmodule // ltpam_core
`default_nettype wire

/* File: ltpam_top_test.sv */
// Self-checking bench for the code-space address mapper
`timescale 1ns/1ps
`default_nettype none
module ltpam_top_test;
	logic        clk_sys, srst, cfg_we, cfg_sel_high, cfg_enable, rom_ub_we;
	logic        acc_valid, acc_code, acc_opcode, acc_internal, bus_valid;
	logic [15:0] log_addr;
	logic [4:0]  cfg_size;
	logic [7:0]  cfg_zone, cfg_operand_byte, cfg_opcode_byte, rom_op, rom_oc;
	logic [23:0] cfg_target;
	logic [31:0] bus_addr;
	logic [1:0]  hit_vec, map_enabled;
	int          error_cnt, checks_done, cyc;
	ltpam_core core (.acc_valid(acc_valid), .acc_code(acc_code),
		.acc_opcode(acc_opcode), .acc_internal(acc_internal),
		.log_addr(log_addr));
	ltpam_top DUT (.clk_sys(clk_sys), .srst(srst), .acc_valid(acc_valid),
		.acc_code(acc_code), .acc_opcode(acc_opcode),
		.acc_internal(acc_internal), .log_addr(log_addr), .cfg_we(cfg_we),
		.cfg_sel_high(cfg_sel_high), .cfg_enable(cfg_enable),
		.cfg_size(cfg_size), .cfg_zone(cfg_zone), .cfg_target(cfg_target),
		.cfg_operand_byte(cfg_operand_byte),
		.cfg_opcode_byte(cfg_opcode_byte), .rom_ub_we(rom_ub_we),
		.rom_operand_upper_byte(rom_op), .rom_opcode_upper_byte(rom_oc),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .hit_vec(hit_vec),
		.map_enabled(map_enabled));
	task automatic chk32(input string n, input logic [31:0] e, s);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic chk2(input string n, input logic [1:0] e, s);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cfg(input logic h, en, input logic [4:0] s,
		input logic [7:0] z, input logic [23:0] t, input logic [7:0] op);
		@(negedge clk_sys);
		cfg_sel_high = h;
		cfg_enable = en;
		cfg_size = s;
		cfg_zone = z;
		cfg_target = t;
		cfg_operand_byte = op;
		cfg_opcode_byte = ~op;
		cfg_we = 1'b1;
		@(negedge clk_sys);
		cfg_we = 1'b0;
	endtask
	task automatic acc(input logic [15:0] a, input logic [2:0] k,
		input logic [31:0] e);
		@(negedge clk_sys);
		core.fetch(a, k);
		#1;
		chk32("bus_addr", e, bus_addr);
		chk2("bus_valid", {1'b0, k[2] & ~k[0]}, {1'b0, bus_valid});
	endtask
	task automatic quiet;
		@(negedge clk_sys);
		core.idle();
		#1;
		chk32("bus_addr", 32'h00000000, bus_addr);
		chk2("bus_valid", 2'h0, {1'b0, bus_valid});
	endtask
	task automatic test_rom;
		rom_op = 8'h5a;
		rom_oc = 8'ha5;
		rom_ub_we = 1'b1;
		@(negedge clk_sys);
		rom_ub_we = 1'b0;
		chk2("map_enabled", 2'h0, map_enabled);
		acc(16'h1277, 3'b100, 32'h5a000277);
		acc(16'hfc05, 3'b110, 32'ha5000005);
		$display("rom mapper test done");
	endtask
	task automatic test_low;
		cfg(1'b0, 1'b1, 5'h08, 8'h12, 24'hab3456, 8'h11);
		chk2("map_enabled", 2'h1, map_enabled);
		acc(16'h1277, 3'b100, 32'h11ab3477);
		acc(16'h1277, 3'b000, 32'h00000000);
		acc(16'h1277, 3'b101, 32'h00000000);
		quiet;
		acc(16'h1377, 3'b100, 32'h5a000377);
		$display("low mapper test done");
	endtask
	task automatic test_priority;
		cfg(1'b1, 1'b1, 5'h0d, 8'h00, 24'h7c0000, 8'h33);
		acc(16'h1277, 3'b100, 32'h337c1277);
		chk2("hit_vec", 2'h3, hit_vec);
		acc(16'h2000, 3'b100, 32'h5a000000);
		cfg(1'b1, 1'b1, 5'h10, 8'h9c, 24'h800000, 8'h77);
		acc(16'h4321, 3'b110, 32'h88804321);
		chk2("hit_vec", 2'h2, hit_vec);
		cfg(1'b1, 1'b0, 5'h10, 8'h9c, 24'h800000, 8'h77);
		chk2("map_enabled", 2'h1, map_enabled);
		acc(16'h1277, 3'b100, 32'h11ab3477);
		$display("priority test done");
	endtask
	task automatic test_reset;
		@(negedge clk_sys);
		srst = 1'b1;
		@(negedge clk_sys);
		srst = 1'b0;
		chk2("map_enabled", 2'h0, map_enabled);
		acc(16'h1277, 3'b100, 32'h00000277);
		$display("second reset test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Whole run needs well under 200 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			results;
		end
	end
	initial
	begin
		srst = 1'b1;
		cfg_we = 1'b0;
		rom_ub_we = 1'b0;
		rom_op = 8'h00;
		rom_oc = 8'h00;
		core.fetch(16'h0000, 3'b000);
		// A write inside reset must be lost
		cfg(1'b0, 1'b1, 5'h08, 8'h12, 24'h000000, 8'h00);
		repeat (6) @(negedge clk_sys);
		srst = 1'b0;
		test_rom;
		test_low;
		test_priority;
		test_reset;
		results;
	end
endmodule // ltpam_top_test
`default_nettype wire
